// file: rtl/ptu_pkg.sv
// package of the protocol timer unit: register map, field layout, types
// assumes a 32-bit classic wishbone master addressing bytes, one word per register
package ptu_pkg;

    // register indices; byte address is four times the index
    localparam logic [5:0] PTU_IDX_MODE       = 6'h2A;
    localparam logic [5:0] PTU_IDX_PRESC_LO   = 6'h2B;
    localparam logic [5:0] PTU_IDX_RELOAD_HI  = 6'h2C;
    localparam logic [5:0] PTU_IDX_RELOAD_LO  = 6'h2D;
    localparam logic [5:0] PTU_IDX_COUNT_HI   = 6'h2E;
    localparam logic [5:0] PTU_IDX_COUNT_LO   = 6'h2F;
    localparam logic [5:0] PTU_IDX_CTRL       = 6'h38;
    localparam logic [5:0] PTU_IDX_STATUS     = 6'h39;

    // timer_mode_control fields
    localparam int PTU_MODE_AUTO_BIT    = 7;
    localparam int PTU_MODE_GATE_HI     = 6;
    localparam int PTU_MODE_GATE_LO     = 5;
    localparam int PTU_MODE_RESTART_BIT = 4;
    localparam int PTU_MODE_PRESC_HI    = 3;

    // misc_control fields
    localparam int PTU_CTRL_EVEN_BIT  = 0;
    localparam int PTU_CTRL_MULTI_BIT = 1;
    localparam int PTU_CTRL_START_BIT = 2;
    localparam int PTU_CTRL_STOP_BIT  = 3;

    // primary_status fields
    localparam int PTU_STAT_RUN_BIT = 0;
    localparam int PTU_STAT_IRQ_BIT = 1;

    // gate_select codes
    localparam logic [1:0] PTU_GATE_NONE = 2'h0;
    localparam logic [1:0] PTU_GATE_PIN_A = 2'h1;
    localparam logic [1:0] PTU_GATE_AUX  = 2'h2;

    // received bits after which an auto-started timer stops
    localparam logic [2:0] PTU_RX_STOP_BITS = 3'h5;

    // reset values
    localparam logic [7:0]  PTU_BYTE_RESET  = 8'h00;
    localparam logic [15:0] PTU_COUNT_RESET = 16'h0000;

    typedef enum logic [1:0] {
        PTU_T_IDLE  = 2'b00,
        PTU_T_RUN   = 2'b01,
        PTU_T_WATCH = 2'b11
    } ptu_tstate_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } ptu_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } ptu_wb_rsp_t;

    typedef struct packed {
        logic [7:0]  mode;
        logic [7:0]  presc_lo;
        logic [7:0]  reload_hi;
        logic [7:0]  reload_lo;
        logic        even_sel;
        logic        multi_rx;
        logic [15:0] count;
        ptu_tstate_t tstate;
        logic [2:0]  rx_cnt;
        logic        irq;
        logic        run_flag;
        logic [1:0]  gate_a_sync;
        logic [1:0]  gate_aux_sync;
        logic        ack;
        logic [31:0] rdat;
    } ptu_state_t;

    localparam ptu_state_t PTU_STATE_RESET = '{
        mode:          PTU_BYTE_RESET,
        presc_lo:      PTU_BYTE_RESET,
        reload_hi:     PTU_BYTE_RESET,
        reload_lo:     PTU_BYTE_RESET,
        even_sel:      1'b0,
        multi_rx:      1'b0,
        count:         PTU_COUNT_RESET,
        tstate:        PTU_T_IDLE,
        rx_cnt:        3'h0,
        irq:           1'b0,
        run_flag:      1'b0,
        gate_a_sync:   2'h0,
        gate_aux_sync: 2'h0,
        ack:           1'b0,
        rdat:          32'h0000_0000
    };

    typedef struct packed {
        logic [25:0] acc;
        logic [12:0] div;
        logic        tick;
    } ptu_presc_state_t;

    localparam ptu_presc_state_t PTU_PRESC_RESET = '{
        acc:  26'h000_0000,
        div:  13'h0000,
        tick: 1'b0
    };

endpackage : ptu_pkg

// file: rtl/ptu_prescaler.sv
// prescaler of the protocol timer: carrier rate enable and programmable divider
// assumes an asynchronous active-low reset whose release the caller has already synchronised
`timescale 1ns/1ns
`default_nettype none

module ptu_prescaler #(
    parameter int CLK_HZ     = 25_000_000,
    parameter int CARRIER_HZ = 13_560_000
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clear,
    input  wire logic        enable,
    input  wire logic        even_sel,
    input  wire logic [11:0] divisor_value,
    output logic             tick
);
    import ptu_pkg::*;

    localparam logic [25:0] CLK_STEP     = 26'(CLK_HZ);
    localparam logic [25:0] CARRIER_STEP = 26'(CARRIER_HZ);

    ptu_presc_state_t st_reg;
    ptu_presc_state_t st_next;
    logic [25:0]      acc_sum;
    logic             carrier_en;
    logic [12:0]      period_m1;

    always_comb begin
        st_next    = st_reg;
        acc_sum    = st_reg.acc + CARRIER_STEP;
        carrier_en = (acc_sum >= CLK_STEP);
        // divider period minus one: 2p for odd formula, 2p+1 for even
        period_m1  = {divisor_value, even_sel};
        st_next.acc  = carrier_en ? (acc_sum - CLK_STEP) : acc_sum;
        st_next.tick = 1'b0;
        if (clear) begin
            st_next.div = period_m1;
        end else if (enable && carrier_en) begin
            if (st_reg.div == 13'h0000) begin
                st_next.div  = period_m1;
                st_next.tick = 1'b1;
            end else begin
                st_next.div = st_reg.div - 13'h0001;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= PTU_PRESC_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tick = st_reg.tick;

endmodule : ptu_prescaler

`default_nettype wire

// file: rtl/ptu_timer.sv
// protocol timer unit: 16-bit count-down timer with wishbone register access
// assumes tx_end and rx_bit are single-cycle pulses from logic on clk;
// gate pins are asynchronous and are synchronised here
//
// Notes on behaviour
// - with auto-start set, every end of transmission starts the timer.
// - with auto-start set and multi-frame receive off, the fifth bit received after a transmission-end start stops the timer.
// - with auto-start set and multi-frame receive on, received bits never stop the timer; stop_timer_now or expiry without auto-reload does.
// - with auto-start clear, transmission end and received bits have no effect on the timer.
// - gate_select 00 is ungated, 01 gates by pin a, 10 by the auxiliary pin, 11 is treated as ungated.
// - in gated mode the running flag shows the timer as enabled by the gate; the flag never drives gating.
// - with auto-reload set, reaching the end of count reloads the counter from the reload value.
// - with auto-reload clear, the counter runs down to zero and then sets the expired flag.
// - the 12-bit prescale value is mode bits 3 to 0 above the prescaler low byte.
// - with even select clear, the tick rate is the carrier over twice the prescale value plus one.
// - with even select set, the tick rate is the carrier over twice the prescale value plus two.
// - the reload value is held in a writable high byte and a writable low byte.
// - every start event loads the counter from the current reload value.
// - writes to the reload bytes leave a running count alone until the next start or auto-reload.
// - the live counter reads back as a high byte and a low byte, both read-only.
`timescale 1ns/1ns
`default_nettype none

module ptu_timer #(
    parameter int CLK_HZ     = 25_000_000,
    parameter int CARRIER_HZ = 13_560_000
) (
    input  wire logic                 clk,
    input  wire logic                 nrst,
    input  wire ptu_pkg::ptu_wb_req_t wb_req,
    output ptu_pkg::ptu_wb_rsp_t      wb_rsp,
    input  wire logic                 tx_end,
    input  wire logic                 rx_bit,
    input  wire logic                 gate_input_pin_a,
    input  wire logic                 auxiliary_gate_pin,
    output logic                      timer_expired_irq,
    output logic                      timer_running_flag
);
    import ptu_pkg::*;

    // gate level for the selected source
    function automatic logic gate_open(input logic [1:0] gsel,
                                       input logic       pin_a,
                                       input logic       pin_aux);
        case (gsel)
            PTU_GATE_PIN_A: gate_open = pin_a;
            PTU_GATE_AUX:   gate_open = pin_aux;
            default:        gate_open = 1'b1;
        endcase
    endfunction : gate_open

    // byte lane 0 of a write, if selected
    function automatic logic [7:0] lane0(input logic [7:0] old_val,
                                         input logic [3:0] sel,
                                         input logic [31:0] dat);
        lane0 = sel[0] ? dat[7:0] : old_val;
    endfunction : lane0

    logic [1:0] rst_sync;
    logic       rst_n;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    assign rst_n = rst_sync[1];

    ptu_state_t  st_reg;
    ptu_state_t  st_next;
    logic        req;
    logic        wr_commit;
    logic [5:0]  idx;
    logic        auto_start;
    logic        auto_reload;
    logic [1:0]  gsel;
    logic [11:0] divisor;
    logic        gate_ok;
    logic        running;
    logic        start_ev;
    logic        stop_ev;
    logic        sw_start;
    logic        sw_stop;
    logic        irq_clr;
    logic        expire;
    logic        tick;
    logic        presc_clear;
    logic [7:0]  rd_byte;

    assign auto_start  = st_reg.mode[PTU_MODE_AUTO_BIT];
    assign auto_reload = st_reg.mode[PTU_MODE_RESTART_BIT];
    assign gsel        = st_reg.mode[PTU_MODE_GATE_HI:PTU_MODE_GATE_LO];
    assign divisor     = {st_reg.mode[PTU_MODE_PRESC_HI:0], st_reg.presc_lo};
    assign running     = (st_reg.tstate != PTU_T_IDLE);
    assign gate_ok     = gate_open(gsel, st_reg.gate_a_sync[1],
                                   st_reg.gate_aux_sync[1]);

    assign req       = wb_req.cyc && wb_req.stb;
    assign wr_commit = req && wb_req.we && st_reg.ack;
    assign idx       = wb_req.adr[7:2];

    assign sw_start = wr_commit && (idx == PTU_IDX_CTRL) && wb_req.sel[0]
                      && wb_req.dat[PTU_CTRL_START_BIT];
    assign sw_stop  = wr_commit && (idx == PTU_IDX_CTRL) && wb_req.sel[0]
                      && wb_req.dat[PTU_CTRL_STOP_BIT];
    assign irq_clr  = wr_commit && (idx == PTU_IDX_STATUS) && wb_req.sel[0]
                      && wb_req.dat[PTU_STAT_IRQ_BIT];

    // protocol start only under auto-start
    assign start_ev = sw_start || (auto_start && tx_end);

    // fifth received bit ends a watched run unless multi-frame receive is on
    assign stop_ev = sw_stop
                     || (st_reg.tstate == PTU_T_WATCH && auto_start && !st_reg.multi_rx
                         && rx_bit && st_reg.rx_cnt == PTU_RX_STOP_BITS - 3'h1);

    // prescaler restarts with each start so the first tick is a full period
    assign presc_clear = start_ev || !running;

    ptu_prescaler #(
        .CLK_HZ     (CLK_HZ),
        .CARRIER_HZ (CARRIER_HZ)
    ) u_presc (
        .clk           (clk),
        .rst_n         (rst_n),
        .clear         (presc_clear),
        .enable        (running && gate_ok),
        // next value so a start written with the even select uses it from the first period
        .even_sel      (st_next.even_sel),
        .divisor_value (divisor),
        .tick          (tick)
    );

    assign expire = running && tick && (st_reg.count == 16'h0000);

    always_comb begin
        case (idx)
            PTU_IDX_MODE:      rd_byte = st_reg.mode;
            PTU_IDX_PRESC_LO:  rd_byte = st_reg.presc_lo;
            PTU_IDX_RELOAD_HI: rd_byte = st_reg.reload_hi;
            PTU_IDX_RELOAD_LO: rd_byte = st_reg.reload_lo;
            PTU_IDX_COUNT_HI:  rd_byte = st_reg.count[15:8];
            PTU_IDX_COUNT_LO:  rd_byte = st_reg.count[7:0];
            PTU_IDX_CTRL: begin
                rd_byte = 8'h00;
                rd_byte[PTU_CTRL_EVEN_BIT]  = st_reg.even_sel;
                rd_byte[PTU_CTRL_MULTI_BIT] = st_reg.multi_rx;
            end
            PTU_IDX_STATUS: begin
                rd_byte = 8'h00;
                rd_byte[PTU_STAT_RUN_BIT] = st_reg.run_flag;
                rd_byte[PTU_STAT_IRQ_BIT] = st_reg.irq;
            end
            default:           rd_byte = 8'h00;
        endcase
    end

    always_comb begin
        st_next = st_reg;

        st_next.gate_a_sync   = {st_reg.gate_a_sync[0], gate_input_pin_a};
        st_next.gate_aux_sync = {st_reg.gate_aux_sync[0], auxiliary_gate_pin};

        // one-wait classic slave: ack in the cycle after the request, dropped after one
        st_next.ack = req && !st_reg.ack;
        if (req && !st_reg.ack) begin
            st_next.rdat = {24'h00_0000, rd_byte};
        end

        if (wr_commit) begin
            case (idx)
                PTU_IDX_MODE: begin
                    st_next.mode = lane0(st_reg.mode, wb_req.sel, wb_req.dat);
                end
                PTU_IDX_PRESC_LO: begin
                    st_next.presc_lo = lane0(st_reg.presc_lo, wb_req.sel, wb_req.dat);
                end
                PTU_IDX_RELOAD_HI: begin
                    st_next.reload_hi = lane0(st_reg.reload_hi, wb_req.sel, wb_req.dat);
                end
                PTU_IDX_RELOAD_LO: begin
                    st_next.reload_lo = lane0(st_reg.reload_lo, wb_req.sel, wb_req.dat);
                end
                PTU_IDX_CTRL: begin
                    if (wb_req.sel[0]) begin
                        st_next.even_sel = wb_req.dat[PTU_CTRL_EVEN_BIT];
                        st_next.multi_rx = wb_req.dat[PTU_CTRL_MULTI_BIT];
                    end
                end
                default: begin
                end
            endcase
        end

        // received bits are counted only while a protocol-started run watches
        if (st_reg.tstate == PTU_T_WATCH && rx_bit && st_reg.rx_cnt != PTU_RX_STOP_BITS) begin
            st_next.rx_cnt = st_reg.rx_cnt + 3'h1;
        end

        case (st_reg.tstate)
            PTU_T_IDLE: begin
            end
            PTU_T_RUN, PTU_T_WATCH: begin
                if (tick) begin
                    if (st_reg.count != 16'h0000) begin
                        st_next.count = st_reg.count - 16'h0001;
                    end else if (auto_reload) begin
                        st_next.count = {st_reg.reload_hi, st_reg.reload_lo};
                    end else begin
                        st_next.tstate = PTU_T_IDLE;
                    end
                end
            end
            default: begin
                st_next.tstate = PTU_T_IDLE;
            end
        endcase

        // start overrides running count; stop wins over start
        if (start_ev) begin
            st_next.count  = {st_reg.reload_hi, st_reg.reload_lo};
            st_next.rx_cnt = 3'h0;
            st_next.tstate = (auto_start && tx_end) ? PTU_T_WATCH : PTU_T_RUN;
        end
        if (stop_ev) begin
            st_next.tstate = PTU_T_IDLE;
        end

        // expired flag: hardware set wins over software clear
        if (irq_clr) begin
            st_next.irq = 1'b0;
        end
        if (expire && !auto_reload) begin
            st_next.irq = 1'b1;
        end

        // running flag follows the gate in gated mode, never the other way
        st_next.run_flag = (st_next.tstate != PTU_T_IDLE)
                           && (gsel == PTU_GATE_NONE || gsel == 2'h3 || gate_ok);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= PTU_STATE_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign wb_rsp.ack         = st_reg.ack;
    assign wb_rsp.dat         = st_reg.rdat;
    assign timer_expired_irq  = st_reg.irq;
    assign timer_running_flag = st_reg.run_flag;

endmodule : ptu_timer

`default_nettype wire

// file: tb/ptu_timer_assertions.sv
// checker for the protocol timer: bus handshake, protocol start and stop, gating, expiry
// assumes it is bound to ptu_timer and sees only that module's ports
`timescale 1ns/1ns
`default_nettype none

module ptu_timer_assertions (
    input wire logic                 clk,
    input wire logic                 nrst,
    input wire ptu_pkg::ptu_wb_req_t wb_req,
    input wire ptu_pkg::ptu_wb_rsp_t wb_rsp,
    input wire logic                 tx_end,
    input wire logic                 rx_bit,
    input wire logic                 gate_input_pin_a,
    input wire logic                 auxiliary_gate_pin,
    input wire logic                 timer_expired_irq,
    input wire logic                 timer_running_flag
);
    import ptu_pkg::*;

    logic       busy;
    logic       wr;
    logic       ungated;
    logic [7:0] mode_q;
    logic       multi_q;
    logic [2:0] rx_n;

    assign busy    = wb_req.cyc && wb_req.stb;
    assign wr      = busy && wb_req.we && wb_req.sel[0] && wb_rsp.ack;
    assign ungated = (mode_q[6:5] == PTU_GATE_NONE) || (mode_q[6:5] == 2'h3);

    // shadow of mode and receive setting, received bits since transmission end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_q  <= 8'h00;
            multi_q <= 1'b0;
            rx_n    <= 3'h0;
        end else begin
            if (wr && wb_req.adr[7:2] == PTU_IDX_MODE) mode_q <= wb_req.dat[7:0];
            if (wr && wb_req.adr[7:2] == PTU_IDX_CTRL) multi_q <= wb_req.dat[PTU_CTRL_MULTI_BIT];
            if (tx_end) rx_n <= 3'h0;
            else if (rx_bit && rx_n != 3'h7) rx_n <= rx_n + 3'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    chk_ack_one_wait: assert property ($rose(busy) |=> wb_rsp.ack)
        else $error("ack not one cycle after request");
    chk_ack_single: assert property (wb_rsp.ack |=> !wb_rsp.ack)
        else $error("ack longer than one cycle");
    chk_ack_needs_req: assert property (wb_rsp.ack |-> busy)
        else $error("ack without request");
    chk_auto_start: assert property (mode_q[7] && ungated && tx_end && !busy |=> timer_running_flag)
        else $error("transmission end did not start timer");
    chk_rx_fifth_stop: assert property (mode_q[7] && !multi_q && rx_bit && rx_n == 3'h4 && !tx_end
        && !busy |=> !timer_running_flag)
        else $error("fifth received bit did not stop timer");
    chk_multi_hold: assert property (mode_q[7] && multi_q && mode_q[6:5] == PTU_GATE_NONE
        && timer_running_flag && rx_bit && !busy |=> timer_running_flag)
        else $error("received bit stopped timer in multi-frame mode");
    chk_no_protocol: assert property (!mode_q[7] && ungated && !timer_running_flag && !busy
        && !$past(busy) |=> !timer_running_flag)
        else $error("timer started without software");
    chk_gate_pin_a: assert property ((mode_q[6:5] == PTU_GATE_PIN_A && !gate_input_pin_a)[*4]
        |-> !timer_running_flag)
        else $error("running flag high with pin a gate closed");
    chk_gate_aux: assert property ((mode_q[6:5] == PTU_GATE_AUX && !auxiliary_gate_pin)[*4]
        |-> !timer_running_flag)
        else $error("running flag high with aux gate closed");
    chk_expiry_stops: assert property ($rose(timer_expired_irq)
        |-> $past(timer_running_flag) && !timer_running_flag)
        else $error("expiry without stopping a running timer");
    chk_irq_sticky: assert property ($fell(timer_expired_irq) |-> $past(wr
        && wb_req.adr[7:2] == PTU_IDX_STATUS && wb_req.dat[PTU_STAT_IRQ_BIT]))
        else $error("expired flag dropped without clear");

endmodule : ptu_timer_assertions

`default_nettype wire

// file: tb/tb_ptu_timer.sv
// self-checking bench of the protocol timer unit over wishbone and protocol pulses
// assumes the design package and the checker are compiled before it
`timescale 1ns/1ns
`default_nettype none

module tb_ptu_timer;
    import ptu_pkg::*;

    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        tx_end = 1'b0;
    logic        rx_bit = 1'b0;
    logic        pin_a = 1'b0;
    logic        pin_aux = 1'b0;
    ptu_wb_req_t req = '0;
    ptu_wb_rsp_t rsp;
    logic        irq;
    logic        run;
    logic [7:0]  rd;
    logic [7:0]  v;
    int          mismatches = 0;
    int          checked = 0;
    logic [5:0]  regs [8] = '{PTU_IDX_MODE, PTU_IDX_PRESC_LO, PTU_IDX_RELOAD_HI,
        PTU_IDX_RELOAD_LO, PTU_IDX_COUNT_HI, PTU_IDX_COUNT_LO, PTU_IDX_STATUS, 6'h3F};

    ptu_timer i_ptu_timer (.clk(clk), .nrst(nrst), .wb_req(req), .wb_rsp(rsp),
        .tx_end(tx_end), .rx_bit(rx_bit), .gate_input_pin_a(pin_a),
        .auxiliary_gate_pin(pin_aux), .timer_expired_irq(irq), .timer_running_flag(run));

    initial forever #20 clk = ~clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d);
        @(posedge clk);
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: {idx, 2'b00}, sel: 4'h1, dat: {24'h0, d}};
        // no cycle count assumed: only the watchdog ends a hung wait
        do begin
            @(posedge clk);
        end while (rsp.ack !== 1'b1);
        rd = rsp.dat[7:0];
        req <= '0;
    endtask : bus

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask : wr

    task automatic rdc(input logic [5:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        check(rd, exp);
    endtask : rdc

    task automatic pulse(input logic is_rx, input int times);
        repeat (times) begin
            @(posedge clk);
            if (is_rx) rx_bit <= 1'b1;
            else tx_end <= 1'b1;
            @(posedge clk);
            rx_bit <= 1'b0;
            tx_end <= 1'b0;
        end
    endtask : pulse

    // one expiry run with a random prescale; checks load, duration, sticky flag
    task automatic rate(input logic e);
        int  p;
        int  r;
        int  n;
        int  exp;
        time t0;
        v = 8'($urandom_range(255));
        p = 256 + int'(v);
        r = $urandom_range(5, 3);
        wr(PTU_IDX_MODE, 8'h01);
        wr(PTU_IDX_PRESC_LO, v);
        wr(PTU_IDX_RELOAD_HI, 8'h00);
        wr(PTU_IDX_RELOAD_LO, 8'(r));
        wr(PTU_IDX_CTRL, {5'h0, 1'b1, 1'b0, e});
        t0 = $time;
        rdc(PTU_IDX_COUNT_HI, 8'h00);
        rdc(PTU_IDX_COUNT_LO, 8'(r));
        wr(PTU_IDX_RELOAD_LO, 8'hF0);
        n = 0;
        while (irq !== 1'b1 && n < 20000) begin
            @(posedge clk);
            n++;
        end
        n = int'(($time - t0) / 40);
        exp = int'(real'((r + 1) * (2 * p + 1 + int'(e))) * 25.0 / 13.56);
        check(32'(n >= exp - 3 && n <= exp + 5), 32'h1);
        rdc(PTU_IDX_STATUS, 8'h02);
        wr(PTU_IDX_STATUS, 8'h02);
        rdc(PTU_IDX_STATUS, 8'h00);
    endtask : rate

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : test_done

    initial begin
        #4_000_000;
        mismatches++;
        test_done;
    end

    initial begin
        void'($urandom(32'h33d4));
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        foreach (regs[i]) rdc(regs[i], 8'h00);
        check({irq, run}, 2'b00);
        $display("test reset values done");
        for (int i = 1; i < 4; i++) begin
            v = 8'($urandom);
            wr(regs[i], v);
            rdc(regs[i], v);
        end
        wr(PTU_IDX_COUNT_HI, 8'h5A);
        rdc(PTU_IDX_COUNT_HI, 8'h00);
        $display("test register access done");
        rate(1'b0);
        rate(1'b1);
        $display("test prescale and expiry done");
        wr(PTU_IDX_MODE, 8'h80);
        wr(PTU_IDX_PRESC_LO, 8'h00);
        wr(PTU_IDX_RELOAD_HI, 8'hFF);
        wr(PTU_IDX_RELOAD_LO, 8'hFF);
        wr(PTU_IDX_CTRL, 8'h00);
        pulse(1'b0, 1);
        repeat (3) @(posedge clk);
        check(run, 1'b1);
        pulse(1'b1, 4);
        repeat (2) @(posedge clk);
        check(run, 1'b1);
        pulse(1'b1, 1);
        repeat (2) @(posedge clk);
        check(run, 1'b0);
        wr(PTU_IDX_CTRL, 8'h02);
        pulse(1'b0, 1);
        pulse(1'b1, 6);
        repeat (2) @(posedge clk);
        check(run, 1'b1);
        wr(PTU_IDX_CTRL, 8'h0A);
        repeat (2) @(posedge clk);
        check(run, 1'b0);
        wr(PTU_IDX_MODE, 8'h00);
        pulse(1'b0, 1);
        repeat (3) @(posedge clk);
        check(run, 1'b0);
        wr(PTU_IDX_CTRL, 8'h04);
        pulse(1'b1, 6);
        repeat (2) @(posedge clk);
        check(run, 1'b1);
        wr(PTU_IDX_CTRL, 8'h08);
        $display("test protocol start and stop done");
        wr(PTU_IDX_MODE, 8'h10);
        wr(PTU_IDX_RELOAD_HI, 8'h00);
        wr(PTU_IDX_RELOAD_LO, 8'h01);
        wr(PTU_IDX_CTRL, 8'h04);
        repeat (60) @(posedge clk);
        check({irq, run}, 2'b01);
        wr(PTU_IDX_CTRL, 8'h08);
        $display("test auto reload done");
        wr(PTU_IDX_RELOAD_HI, 8'hFF);
        for (int g = 1; g < 4; g++) begin
            wr(PTU_IDX_MODE, {1'b0, 2'(g), 5'h00});
            pin_a <= (g == 2);
            pin_aux <= (g == 1);
            wr(PTU_IDX_CTRL, 8'h04);
            repeat (600) @(posedge clk);
            check(run, 32'(g == 3));
            // ungated: about 326 ticks from FF01 leaves the high byte at FD
            rdc(PTU_IDX_COUNT_HI, (g == 3) ? 8'hFD : 8'hFF);
            pin_a <= 1'b1;
            pin_aux <= 1'b1;
            repeat (4) @(posedge clk);
            check(run, 1'b1);
            wr(PTU_IDX_CTRL, 8'h08);
            pin_a <= 1'b0;
            pin_aux <= 1'b0;
        end
        $display("test gating done");
        test_done;
    end

endmodule : tb_ptu_timer

bind ptu_timer ptu_timer_assertions i_ptu_timer_assertions (.clk(clk), .nrst(nrst),
    .wb_req(wb_req), .wb_rsp(wb_rsp), .tx_end(tx_end), .rx_bit(rx_bit),
    .gate_input_pin_a(gate_input_pin_a), .auxiliary_gate_pin(auxiliary_gate_pin),
    .timer_expired_irq(timer_expired_irq), .timer_running_flag(timer_running_flag));

`default_nettype wire
